// *** hdl/ppc_defs.svh ***
// Constants for the single-port power controller: offsets, fields, timings.
// Assumes a 100 MHz core clock and an AHB-Lite register bus.
//
// Summary of operation
// R1 - Wait 1.3 s after a current fault.
// R2 - Old-device mode backoff nominally 3 s.
// R3 - Midspan backoff nominally 2.5 s.
// R4 - Wait 1.3 s after keep-alive dropout.
// R5 - Start-up current limit allowed 59 ms.
// R6 - Overcurrent after start-up allowed 59 ms.
// R7 - Fault timer trips above 6.3 percent duty.
// R8 - Extended, twin or extreme: 12 ms limit.
// R9 - Standard or old devices: 59 ms limit.
// R10 - Keep-alive pulse of 3.6 ms restarts timer; the code restarts it after a 3 ms pulse.
// R11 - No keep-alive for 350 ms removes power.
// R12 - Reset pin ignores lows under 4.5 us.
// R13 - Reset low keeps port off and idle.
// R14 - Midspan select picks midspan timing.
// R15 - Old-device mode accepts four detect outcomes.
// R16 - Old-device mode gives classes 0-3 13W.
// R17 - Otherwise only detect-good is valid.
// R18 - Twin signature needs 52.7W level or above.
// R19 - Power level selects one of seven.
// R20 - Indicator pulls low while port powered.
// R21 - Overcurrent makes the fault timer count up.
// R22 - Fault timer expiry pulls the switch down.
// R23 - Configuration captured only at reset release.
// R24 - 13W mode: one event, class 4 as 0.
// R25 - Detect-good proceeds to classification.
// R26 - All intervals except the reset pin filter counted from a millisecond tick.
// R27 - Invalid detection backs off, then retries forever.
`ifndef PPC_DEFS_SVH
`define PPC_DEFS_SVH

`define PPC_CLK_PERIOD_NS        10
`define PPC_TICK_CYCLES          100000
`define PPC_RST_MIN_NS           4500
`define PPC_FAULT_RETRY_DELAY_MS 1300
`define PPC_LEGACY_BACKOFF_MS    3000
`define PPC_MIDSPAN_BACKOFF_MS   2500
`define PPC_ENDPOINT_BACKOFF_MS  100
`define PPC_DISCONNECT_DELAY_MS  1300
`define PPC_STARTUP_WINDOW_MS    59
`define PPC_OVERCURRENT_WINDOW_MS 59
`define PPC_LIMIT_WINDOW_LONG_MS 59
`define PPC_LIMIT_WINDOW_SHORT_MS 12
`define PPC_KEEPALIVE_PULSE_MS   3
`define PPC_KEEPALIVE_DROPOUT_MS 350
`define PPC_FT_UP_STEP           15
`define PPC_FT_DOWN_STEP         1

`define PPC_REG_CTRL             8'h00
`define PPC_REG_STATUS           8'h04
`define PPC_REG_EVENTS           8'h08
`define PPC_REG_CONFIG           8'h0C
`define PPC_CTRL_ENABLE_RST      1'b1

`endif

// *** hdl/ppc_pkg.sv ***
// Types for the single-port power controller.
// Assumes ppc_defs.svh supplies all numeric constants.
package ppc_pkg;

  typedef enum logic [5:0] {
    ST_IDLE     = 6'h01,
    ST_DETECT   = 6'h02,
    ST_CLASSIFY = 6'h04,
    ST_STARTUP  = 6'h08,
    ST_POWERED  = 6'h10,
    ST_BACKOFF  = 6'h20
  } ppc_state_t;

  typedef enum logic [2:0] {
    LVL_13W = 3'h0, LVL_25W = 3'h1, LVL_38W = 3'h2, LVL_52W = 3'h3,
    LVL_70W = 3'h4, LVL_90W = 3'h5, LVL_EXTREME = 3'h6, LVL_RSVD = 3'h7
  } ppc_level_t;

  typedef enum logic [2:0] {
    DET_UNKNOWN = 3'h0, DET_SHORT = 3'h1, DET_CAP_HIGH = 3'h2, DET_SIG_LOW = 3'h3,
    DET_GOOD = 3'h4, DET_SIG_HIGH = 3'h5, DET_OPEN = 3'h6, DET_VOLT_OUT = 3'h7
  } ppc_det_t;

endpackage

// *** hdl/ppc_port_ctrl.sv ***
// Single-port power sequencer: detect, classify, power, fault and retry timing.
// Assumes analog front-end handshakes and comparators synchronous to core_clk.
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`include "ppc_defs.svh"

module ppc_port_ctrl #(
  parameter int TICK_CYCLES = `PPC_TICK_CYCLES
) (
  // Clock, reset and freeze.
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  // Register bus.
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Reset pin and configuration straps.
  input  wire logic        port_reset_n,
  input  wire logic        midspan_sel,
  input  wire logic        legacy_enable,
  input  wire logic        twin_signature_enable,
  input  wire logic [2:0]  power_level_select,
  // Detection and classification front end.
  output logic             det_start,
  input  wire logic        det_done,
  input  wire logic [2:0]  det_result,
  output logic             class_start,
  output logic             class_two_event,
  input  wire logic        class_done,
  input  wire logic [2:0]  class_result,
  input  wire logic        twin_detected,
  // Current and keep-alive comparators.
  input  wire logic        overcurrent_threshold,
  input  wire logic        limit_threshold,
  input  wire logic        keepalive_signature,
  // Pass switch, indicator and allocation.
  output logic             gate_on,
  output logic             gate_pulldown,
  output logic             status_led_o,
  output logic             status_led_oe,
  output logic [2:0]       alloc_level
);

  localparam int RST_FILT_CYC = (`PPC_RST_MIN_NS + `PPC_CLK_PERIOD_NS - 1) / `PPC_CLK_PERIOD_NS;
  localparam int RFW          = $clog2(RST_FILT_CYC + 1);
  localparam int TW           = $clog2(TICK_CYCLES + 1);
  localparam int MW           = 12;
  localparam int FT_LIMIT     = `PPC_OVERCURRENT_WINDOW_MS * `PPC_FT_UP_STEP;

  ppc_pkg::ppc_state_t state_reg;
  ppc_pkg::ppc_level_t cfg_level_reg;
  logic [RFW-1:0]      rst_cnt_reg;
  logic                hold_reg;
  logic                cfg_mid_reg;
  logic                cfg_legacy_reg;
  logic                cfg_twin_reg;
  logic [TW-1:0]       tick_cnt_reg;
  logic                tick_reg;
  logic [MW-1:0]       ms_cnt_reg;
  logic [MW-1:0]       lim_cnt_reg;
  logic [MW-1:0]       ft_reg;
  logic [MW-1:0]       drop_cnt_reg;
  logic [1:0]          ka_cnt_reg;
  logic                short_lim_reg;
  logic                twin_active_reg;
  logic                ctrl_enable_reg;
  logic [2:0]          events_reg;
  logic                ap_valid_reg;
  logic                ap_write_reg;
  logic [7:0]          ap_addr_reg;
  logic                on_port;
  logic                run;
  logic [MW-1:0]       lim_window;
  logic                lim_expire;
  logic                ft_expire;
  logic                ka_restart;
  logic                drop_expire;
  logic                fault_now;
  logic                disc_now;
  logic                invalid_now;
  logic                wr_events;

  function automatic logic det_valid(input logic [2:0] res, input logic legacy);
    if (legacy) begin
      det_valid = (res == ppc_pkg::DET_SIG_LOW) || (res == ppc_pkg::DET_GOOD) ||  // R15
                  (res == ppc_pkg::DET_SIG_HIGH) || (res == ppc_pkg::DET_CAP_HIGH);
    end else begin
      det_valid = (res == ppc_pkg::DET_GOOD);  // R17
    end
  endfunction

  function automatic logic [MW-1:0] backoff_ms(input logic legacy, input logic mid);
    if (legacy) begin
      backoff_ms = MW'(`PPC_LEGACY_BACKOFF_MS - 1);  // R2
    end else if (mid) begin
      backoff_ms = MW'(`PPC_MIDSPAN_BACKOFF_MS - 1);  // R3
    end else begin
      backoff_ms = MW'(`PPC_ENDPOINT_BACKOFF_MS - 1);  // R14
    end
  endfunction

  function automatic ppc_pkg::ppc_level_t alloc_for(input logic [2:0] cls,
                                                    input ppc_pkg::ppc_level_t lvl,
                                                    input logic twin);
    logic [2:0] eff;
    eff = ((lvl == ppc_pkg::LVL_13W) && (cls == 3'h4)) ? 3'h0 : cls;  // R24
    if (lvl == ppc_pkg::LVL_EXTREME) begin
      alloc_for = ppc_pkg::LVL_EXTREME;
    end else if (twin) begin
      alloc_for = ppc_pkg::LVL_52W;  // R18
    end else if (eff <= 3'h3) begin
      alloc_for = ppc_pkg::LVL_13W;  // R16
    end else if (eff == 3'h4) begin
      alloc_for = ppc_pkg::LVL_25W;
    end else begin
      alloc_for = lvl;  // R19
    end
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] addr);
    unique case (addr)
      `PPC_REG_CTRL:   rd_word = {31'h0, ctrl_enable_reg};
      `PPC_REG_STATUS: rd_word = {15'h0, twin_active_reg, short_lim_reg, alloc_level, 2'h0,
                                  status_led_oe, gate_on, 2'h0, state_reg};
      `PPC_REG_EVENTS: rd_word = {29'h0, events_reg};
      `PPC_REG_CONFIG: rd_word = {26'h0, cfg_level_reg, cfg_twin_reg, cfg_legacy_reg,
                                  cfg_mid_reg};
      default:         rd_word = 32'h0000_0000;
    endcase
  endfunction

  // Reset pin filter: only a low lasting the minimum width asserts the hold.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_cnt_reg <= '0;
      hold_reg    <= 1'b1;
    end else if (clk_en) begin
      if (port_reset_n) begin
        rst_cnt_reg <= '0;
        hold_reg    <= 1'b0;
      end else if (rst_cnt_reg == RFW'(RST_FILT_CYC - 1)) begin
        hold_reg <= 1'b1;  // R12
      end else begin
        rst_cnt_reg <= rst_cnt_reg + RFW'(1);
      end
    end
  end

  // Configuration straps are sampled on the release of the hold.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_mid_reg    <= 1'b0;
      cfg_legacy_reg <= 1'b0;
      cfg_twin_reg   <= 1'b0;
      cfg_level_reg  <= ppc_pkg::LVL_13W;
    end else if (clk_en && hold_reg && port_reset_n) begin
      cfg_mid_reg    <= midspan_sel;  // R23
      cfg_legacy_reg <= legacy_enable;
      cfg_twin_reg   <= twin_signature_enable;
      cfg_level_reg  <= ppc_pkg::ppc_level_t'(power_level_select);
    end
  end

  // Millisecond tick prescaler.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (clk_en) begin
      if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) begin
        tick_cnt_reg <= '0;
        tick_reg     <= 1'b1;  // R26
      end else begin
        tick_cnt_reg <= tick_cnt_reg + TW'(1);
        tick_reg     <= 1'b0;
      end
    end
  end

  // Window and expiry decisions.
  always_comb begin
    on_port    = (state_reg == ppc_pkg::ST_STARTUP) || (state_reg == ppc_pkg::ST_POWERED);
    run        = !hold_reg && ctrl_enable_reg;
    if (state_reg == ppc_pkg::ST_STARTUP) begin
      lim_window = MW'(`PPC_STARTUP_WINDOW_MS);  // R5
    end else if (short_lim_reg) begin
      lim_window = MW'(`PPC_LIMIT_WINDOW_SHORT_MS);  // R8
    end else begin
      lim_window = MW'(`PPC_LIMIT_WINDOW_LONG_MS);  // R9
    end
    lim_expire  = on_port && tick_reg && limit_threshold &&
                  (lim_cnt_reg == lim_window - MW'(1));
    ft_expire   = (state_reg == ppc_pkg::ST_POWERED) && tick_reg && overcurrent_threshold &&
                  (ft_reg >= MW'(FT_LIMIT - `PPC_FT_UP_STEP));  // R6
    ka_restart  = tick_reg && keepalive_signature &&
                  (ka_cnt_reg == 2'(`PPC_KEEPALIVE_PULSE_MS - 1));  // R10
    drop_expire = (state_reg == ppc_pkg::ST_POWERED) && tick_reg && !ka_restart &&
                  (drop_cnt_reg == MW'(`PPC_KEEPALIVE_DROPOUT_MS - 1));  // R11
    fault_now   = run && (lim_expire || ft_expire);
    disc_now    = run && !lim_expire && !ft_expire && drop_expire;
    invalid_now = run && (state_reg == ppc_pkg::ST_DETECT) && det_done &&
                  !det_valid(det_result, cfg_legacy_reg);
    wr_events   = ap_valid_reg && ap_write_reg && (ap_addr_reg == `PPC_REG_EVENTS);
  end

  // Continuous current-limit duration counter.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lim_cnt_reg <= '0;
    end else if (clk_en) begin
      if (!on_port || !limit_threshold) begin
        lim_cnt_reg <= '0;
      end else if (tick_reg) begin
        lim_cnt_reg <= lim_cnt_reg + MW'(1);
      end
    end
  end

  // Leaky overcurrent fault timer: up fast while over, down slowly otherwise.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ft_reg <= '0;
    end else if (clk_en) begin
      if (state_reg != ppc_pkg::ST_POWERED) begin
        ft_reg <= '0;
      end else if (tick_reg && overcurrent_threshold) begin
        ft_reg <= ft_reg + MW'(`PPC_FT_UP_STEP);  // R21
      end else if (tick_reg && ft_reg != '0) begin
        ft_reg <= ft_reg - MW'(`PPC_FT_DOWN_STEP);  // R7
      end
    end
  end

  // Keep-alive pulse width and dropout timers.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ka_cnt_reg   <= '0;
      drop_cnt_reg <= '0;
    end else if (clk_en) begin
      if (state_reg != ppc_pkg::ST_POWERED) begin
        ka_cnt_reg   <= '0;
        drop_cnt_reg <= '0;
      end else if (tick_reg) begin
        if (!keepalive_signature) begin
          ka_cnt_reg <= '0;
        end else if (ka_cnt_reg != 2'(`PPC_KEEPALIVE_PULSE_MS - 1)) begin
          ka_cnt_reg <= ka_cnt_reg + 2'(1);
        end
        if (ka_restart) begin
          drop_cnt_reg <= '0;  // R10
        end else begin
          drop_cnt_reg <= drop_cnt_reg + MW'(1);
        end
      end
    end
  end

  // Port sequencer.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg       <= ppc_pkg::ST_IDLE;
      ms_cnt_reg      <= '0;
      det_start       <= 1'b0;
      class_start     <= 1'b0;
      class_two_event <= 1'b0;
      gate_on         <= 1'b0;
      gate_pulldown   <= 1'b0;
      status_led_o    <= 1'b0;
      status_led_oe   <= 1'b0;
      alloc_level     <= 3'h0;
      short_lim_reg   <= 1'b0;
      twin_active_reg <= 1'b0;
    end else if (clk_en) begin
      det_start   <= 1'b0;
      class_start <= 1'b0;
      if (!run) begin
        state_reg     <= ppc_pkg::ST_IDLE;  // R13
        gate_on       <= 1'b0;
        gate_pulldown <= 1'b0;
        status_led_oe <= 1'b0;
      end else if (fault_now) begin
        state_reg     <= ppc_pkg::ST_BACKOFF;  // R5
        gate_on       <= 1'b0;
        gate_pulldown <= 1'b1;  // R22
        status_led_oe <= 1'b0;
        ms_cnt_reg    <= MW'(`PPC_FAULT_RETRY_DELAY_MS - 1);  // R1
      end else begin
        unique case (state_reg)
          ppc_pkg::ST_IDLE: begin
            state_reg <= ppc_pkg::ST_DETECT;
            det_start <= 1'b1;
          end
          ppc_pkg::ST_DETECT: begin
            if (det_done && !invalid_now) begin
              state_reg       <= ppc_pkg::ST_CLASSIFY;  // R25
              class_start     <= 1'b1;
              class_two_event <= (cfg_level_reg != ppc_pkg::LVL_13W);  // R24
            end else if (invalid_now) begin
              state_reg  <= ppc_pkg::ST_BACKOFF;  // R27
              ms_cnt_reg <= backoff_ms(cfg_legacy_reg, cfg_mid_reg);
            end
          end
          ppc_pkg::ST_CLASSIFY: begin
            if (class_done) begin
              twin_active_reg <= cfg_twin_reg && twin_detected &&
                                 (cfg_level_reg >= ppc_pkg::LVL_52W) &&
                                 (cfg_level_reg != ppc_pkg::LVL_EXTREME);  // R18
              alloc_level     <= alloc_for(class_result, cfg_level_reg,
                                           cfg_twin_reg && twin_detected &&
                                           (cfg_level_reg >= ppc_pkg::LVL_52W));
              short_lim_reg   <= (cfg_level_reg == ppc_pkg::LVL_EXTREME) ||
                                 (cfg_twin_reg && twin_detected &&
                                  (cfg_level_reg >= ppc_pkg::LVL_52W)) ||
                                 ((class_result > 3'h4) &&
                                  (cfg_level_reg >= ppc_pkg::LVL_38W));  // R8
              gate_on         <= 1'b1;
              status_led_oe   <= 1'b1;  // R20
              state_reg       <= ppc_pkg::ST_STARTUP;
            end
          end
          ppc_pkg::ST_STARTUP: begin
            if (!limit_threshold) begin
              state_reg <= ppc_pkg::ST_POWERED;
            end
          end
          ppc_pkg::ST_POWERED: begin
            if (disc_now) begin
              state_reg     <= ppc_pkg::ST_BACKOFF;
              gate_on       <= 1'b0;
              status_led_oe <= 1'b0;
              ms_cnt_reg    <= MW'(`PPC_DISCONNECT_DELAY_MS - 1);  // R4
            end
          end
          ppc_pkg::ST_BACKOFF: begin
            if (tick_reg) begin
              if (ms_cnt_reg == '0) begin
                state_reg     <= ppc_pkg::ST_DETECT;  // R27
                det_start     <= 1'b1;
                gate_pulldown <= 1'b0;
              end else begin
                ms_cnt_reg <= ms_cnt_reg - MW'(1);
              end
            end
          end
          default: begin
            state_reg <= ppc_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Sticky event flags, write one to clear; a new event wins over the clear.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      events_reg <= '0;
    end else if (clk_en) begin
      events_reg <= (events_reg & ~(wr_events ? hwdata[2:0] : 3'h0)) |
                    {invalid_now, disc_now, fault_now};
    end
  end

  // Control register.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_enable_reg <= `PPC_CTRL_ENABLE_RST;
    end else if (clk_en && ap_valid_reg && ap_write_reg && ap_addr_reg == `PPC_REG_CTRL) begin
      ctrl_enable_reg <= hwdata[0];
    end
  end

  // Bus slave: zero wait states, read data registered at the address phase.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg  <= 8'h00;
      hrdata       <= 32'h0000_0000;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end else if (clk_en) begin
      if (hready && hsel && htrans[1]) begin
        ap_valid_reg <= 1'b1;
        ap_write_reg <= hwrite;
        ap_addr_reg  <= haddr;
        hrdata       <= hwrite ? 32'h0000_0000 : rd_word(haddr);
      end else begin
        ap_valid_reg <= 1'b0;
        ap_write_reg <= 1'b0;
      end
    end
  end

endmodule

// *** verification/ppc_pd_model.sv ***
// Behavioural powered device: answers detect and classify after a lag.
// Assumes the bench sets the outcome codes and the load flags.
module ppc_pd_model (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Requests and switch from the controller.
  input  wire logic       det_start,
  input  wire logic       class_start,
  input  wire logic       gate_on,
  // Settings from the bench.
  input  wire logic [2:0] det_code,
  input  wire logic [2:0] class_code,
  input  wire logic [4:0] lag,
  input  wire logic       ka_en,
  input  wire logic       lim_en,
  // Answers and load.
  output logic            det_done,
  output logic [2:0]      det_result,
  output logic            class_done,
  output logic [2:0]      class_result,
  output logic            twin_detected,
  output logic            keepalive_signature,
  output logic            limit_threshold,
  output logic            overcurrent_threshold
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] cnt;
  logic [2:0] pat;
  logic       busy;
  logic       is_cls;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 5'h0;
      pat <= 3'h0;
      busy <= 1'b0;
      is_cls <= 1'b0;
      det_done <= 1'b0;
      class_done <= 1'b0;
      det_result <= 3'h0;
      class_result <= 3'h0;
    end else begin
      pat <= pat + 3'h3;
      det_done <= 1'b0;
      class_done <= 1'b0;
      det_result <= pat;
      class_result <= ~pat;
      if (det_start | class_start) begin
        busy <= 1'b1;
        is_cls <= class_start;
        cnt <= lag;
      end else if (busy && cnt == 5'h0) begin
        busy <= 1'b0;
        det_done <= ~is_cls;
        class_done <= is_cls;
        if (is_cls) class_result <= class_code;
        else det_result <= det_code;
      end else if (busy) begin
        cnt <= cnt - 5'h1;
      end
    end
  end

  assign twin_detected = 1'b0;
  assign keepalive_signature = gate_on & ka_en;
  assign limit_threshold = gate_on & lim_en;
  assign overcurrent_threshold = gate_on & lim_en;
endmodule

// *** verification/ppc_port_checker.sv ***
// Concurrent checks on the port sequencer, bound to its top module.
// Assumes clk_en stays high and the partner answers only after a request.
module ppc_port_checker #(
  parameter int TICK_CYCLES = 10
) (
  // Clock and resets.
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       port_reset_n,
  // Sequencing handshakes.
  input wire logic       det_start,
  input wire logic       det_done,
  input wire logic [2:0] det_result,
  input wire logic       class_start,
  input wire logic       class_done,
  // Load and switch.
  input wire logic       limit_threshold,
  input wire logic       keepalive_signature,
  input wire logic       gate_on,
  input wire logic       gate_pulldown,
  input wire logic       status_led_o,
  input wire logic       status_led_oe
);
  localparam int BIG = 1 << 24;
  int   lo_n;
  int   lim_n;
  int   ka_n;
  int   off_n;
  logic dp;
  logic cp;
  logic g_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dp <= 1'b0;
      cp <= 1'b0;
    end else begin
      dp <= det_start | (dp & ~det_done);
      cp <= class_start | (cp & ~class_done);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lo_n <= 0;
      lim_n <= 0;
      ka_n <= 0;
    end else begin
      lo_n <= port_reset_n ? 0 : lo_n + 1;
      lim_n <= (gate_on & limit_threshold) ? lim_n + 1 : 0;
      ka_n <= (gate_on & ~keepalive_signature) ? ka_n + 1 : 0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      g_q <= 1'b0;
      off_n <= BIG;
    end else begin
      g_q <= gate_on;
      if (!port_reset_n) off_n <= BIG;
      else if (g_q & ~gate_on) off_n <= 0;
      else if (off_n < BIG) off_n <= off_n + 1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_led_powered: assert property (status_led_oe == gate_on && !status_led_o)
    else $error("Indicator does not follow the switch.");
  a_good_classify: assert property (dp && det_done && det_result == 3'h4 |=> class_start)
    else $error("Good detection not followed by classification.");
  a_bad_no_class: assert property (dp && det_done && det_result inside {3'h0, 3'h1, 3'h6, 3'h7}
    |=> !class_start)
    else $error("Invalid detection went on to classification.");
  a_class_powers: assert property (cp && class_done |=> gate_on)
    else $error("Classified device not powered.");
  a_pulldown_off: assert property (gate_pulldown |-> !gate_on)
    else $error("Switch on while pulled down.");
  a_limit_bound: assert property (lim_n <= 60 * TICK_CYCLES)
    else $error("Current limit tolerated too long.");
  a_dropout_bound: assert property (ka_n <= 351 * TICK_CYCLES)
    else $error("Power kept without keep-alive too long.");
  a_retry_gap: assert property (det_start |-> off_n >= 1299 * TICK_CYCLES - 2)
    else $error("Detection retried too soon after power removal.");
  a_reset_idle: assert property (lo_n > 455 |-> !gate_on && !det_start)
    else $error("Port active while reset pin held low.");
endmodule

bind ppc_port_ctrl ppc_port_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.core_clk, .nrst,
  .port_reset_n, .det_start, .det_done, .det_result, .class_start, .class_done,
  .limit_threshold, .keepalive_signature, .gate_on, .gate_pulldown, .status_led_o,
  .status_led_oe);

// *** verification/ppc_port_power_controller_bench.sv ***
// Self-checking bench for the port sequencer with a behavioural device.
// Assumes a shortened millisecond tick of T core clock cycles.
module ppc_port_power_controller_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int T = 10;
  logic core_clk = 0, nrst = 0, clk_en = 1, hsel = 0, hwrite = 0, port_reset_n = 0;
  logic midspan_sel = 0, legacy_enable = 0, twin_signature_enable = 0, ka_en = 1, lim_en = 0;
  logic [7:0]  haddr = '0;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2, power_level_select = '0, det_code = 3'h3, class_code = '0;
  logic [31:0] hwdata = '0, hrdata, rd;
  logic [4:0]  lag = 5'hC;
  logic        hreadyout, hresp, det_start, det_done, class_start, class_two_event, class_done;
  logic        twin_detected, overcurrent_threshold, limit_threshold, keepalive_signature;
  logic        gate_on, gate_pulldown, status_led_o, status_led_oe;
  logic [2:0]  det_result, class_result, alloc_level;
  wire         hready = hreadyout;
  int          n_mismatch = 0, checked = 0, cyc = 0, n;

  always #5 core_clk = ~core_clk;

  ppc_port_ctrl #(.TICK_CYCLES(T)) dut (.*);
  ppc_pd_model pd (.*);

  task automatic stop_test;
    $display("Counts: checked=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 100000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] win(input int k, input int lo, input int hi);
    return 32'(k >= lo * T - 8 && k <= hi * T + 8);
  endfunction

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  task automatic wait_on(input logic g, input logic v, output int k);
    k = 0;
    do begin @(posedge core_clk); k++; end while ((g ? gate_on : det_start) !== v);
  endtask

  task automatic gap_det(output int k);
    do @(posedge core_clk); while (det_done !== 1'b1);
    wait_on(1'b0, 1'b1, k);
  endtask

  task automatic cfg(input logic m, input logic l, input logic tw, input logic [2:0] lv);
    port_reset_n <= 1'b0;
    {midspan_sel, legacy_enable, twin_signature_enable, power_level_select} <= {m, l, tw, lv};
    repeat (460) @(posedge core_clk);
    chk(32'(gate_on), 32'h0);
    port_reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    {midspan_sel, legacy_enable, twin_signature_enable, power_level_select} <= 6'($urandom);
    xfer(1'b0, 8'h0C, '0, rd);
    chk({hresp, rd[5:0]}, {1'b0, lv, tw, l, m});
  endtask

  initial begin
    void'($urandom(56));
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    lag <= 5'($urandom_range(12, 20));
    cfg(1'b0, 1'b0, 1'b0, 3'h0);
    xfer(1'b0, 8'h10, '0, rd);
    chk(rd, 32'h0);
    gap_det(n);
    chk(win(n, 99, 100), 32'h1);
    xfer(1'b0, 8'h08, '0, rd);
    det_code <= 3'h4;
    class_code <= 3'($urandom_range(0, 3));
    chk(rd & 32'h4, 32'h4);
    wait_on(1'b1, 1'b1, n);
    chk({30'h0, class_two_event, status_led_oe}, 32'h1);
    $display("Test endpoint detection done");
    port_reset_n <= 1'b0;
    repeat (100) @(posedge core_clk);
    port_reset_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk(32'(gate_on), 32'h1);
    ka_en <= 1'b0;
    wait_on(1'b1, 1'b0, n);
    chk(win(n, 347, 351), 32'h1);
    xfer(1'b0, 8'h08, '0, rd);
    chk(rd & 32'h2, 32'h2);
    ka_en <= 1'b1;
    lim_en <= 1'b1;
    wait_on(1'b0, 1'b1, n);
    chk(win(n, 1299, 1300), 32'h1);
    $display("Test disconnect done");
    wait_on(1'b1, 1'b1, n);
    wait_on(1'b1, 1'b0, n);
    chk(win(n, 58, 59), 32'h1);
    chk(32'(gate_pulldown), 32'h1);
    lim_en <= 1'b0;
    det_code <= 3'h6;
    xfer(1'b0, 8'h08, '0, rd);
    chk(rd & 32'h1, 32'h1);
    xfer(1'b1, 8'h08, 32'h3, rd);
    xfer(1'b0, 8'h08, '0, rd);
    chk(rd & 32'h3, 32'h0);
    wait_on(1'b0, 1'b1, n);
    chk(win(n, 1290, 1300), 32'h1);
    $display("Test fault retry done");
    det_code <= 3'h5;
    cfg(1'b1, 1'b0, 1'b0, 3'($urandom_range(0, 6)));
    gap_det(n);
    chk(win(n, 2499, 2500), 32'h1);
    $display("Test midspan backoff done");
    det_code <= 3'h3;
    cfg(1'b0, 1'b1, 1'b0, 3'h1);
    wait_on(1'b1, 1'b1, n);
    chk(32'(alloc_level), 32'h0);
    det_code <= 3'h1;
    cfg(1'b0, 1'b1, 1'b0, 3'h1);
    gap_det(n);
    chk(win(n, 2999, 3000), 32'h1);
    $display("Test old-device mode done");
    stop_test();
  end
endmodule
